// ===== verilog/icc_cfg.svh
/*
 * Constants for the eight-channel input capture unit: register offsets,
 * field positions, write mask, prescaler terminal counts and reset values.
 * Assumes it is included by its bare name from files under verilog/.
 */
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH

// -----------------------------------------------------------------------------
// Register map: per channel a control word and a buffer word, 4-byte stride.
// -----------------------------------------------------------------------------
`define ICC_ADDR_W         8
`define ICC_BUF_OFS        8'h00
`define ICC_CON_OFS        8'h02
`define ICC_CH_STRIDE_LOG2 2
`define ICC_IRQ_STAT_OFS   8'h40
`define ICC_IRQ_CLR_OFS    8'h44
`define ICC_IRQ_EN_OFS     8'h48

// -----------------------------------------------------------------------------
// Control word field positions.
// -----------------------------------------------------------------------------
`define ICC_MODE_LSB   0
`define ICC_MODE_MSB   2
`define ICC_BNE_BIT    3
`define ICC_OV_BIT     4
`define ICC_EPI_LSB    5
`define ICC_EPI_MSB    6
`define ICC_TSEL_BIT   7
`define ICC_CON_RESET  16'h0000
`define ICC_CON_WMASK  16'h00E7

// -----------------------------------------------------------------------------
// Prescaler terminal counts.
// -----------------------------------------------------------------------------
`define ICC_DIV4_LAST  4'h3
`define ICC_DIV16_LAST 4'hF

`endif

// ===== verilog/icc_pkg.sv
/*
 * Types shared by the input capture unit files.
 * Assumes icc_cfg.svh is available on the include path.
 */
`default_nettype none

package icc_pkg;
    // Capture mode field codes.
    typedef enum logic [2:0] {
        ICC_MODE_OFF   = 3'b000,
        ICC_MODE_BOTH  = 3'b001,
        ICC_MODE_FALL  = 3'b010,
        ICC_MODE_RISE  = 3'b011,
        ICC_MODE_DIV4  = 3'b100,
        ICC_MODE_DIV16 = 3'b101,
        ICC_MODE_RSV   = 3'b110,
        ICC_MODE_WAKE  = 3'b111
    } icc_mode_e;
endpackage

`default_nettype wire

// ===== verilog/icc_fifo.sv
/*
 * Four-deep shift FIFO holding capture values for one channel.
 * Assumes push is never asked while full; the caller checks count.
 * A read of an empty FIFO returns whatever stands in the head register.
 */
`timescale 1ns/1ps
`default_nettype none

module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_ce,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_head,
    output logic      [2:0]       o_count
);
    // -------------------------------------------------------------------------
    // Storage.
    // -------------------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];    // Entry 0 is always the oldest.
    logic [2:0]       next_count;     // Fill level after this cycle.

    // Fill level follows pushes and pops; a pop on empty does nothing.
    always_comb begin
        next_count = o_count;
        // A pop on empty must not swallow a push that lands in the same cycle.
        if (i_push && !(i_pop && o_count != 3'h0)) begin
            next_count = o_count + 3'h1;
        end else if (i_pop && !i_push && o_count != 3'h0) begin
            next_count = o_count - 3'h1;
        end
    end

    // Count register.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_count <= 3'h0;
        end else if (i_ce) begin
            o_count <= next_count;
        end
    end

    // Entries shift forward by one on a pop; the push lands after the last live one.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    mem[g] <= '0;
                end else if (i_ce) begin
                    if (i_pop && o_count != 3'h0) begin
                        if (i_push && 3'(g) == o_count - 3'h1) begin
                            mem[g] <= i_data;
                        end else if (g < DEPTH - 1) begin
                            mem[g] <= mem[(g + 1) % DEPTH];
                        end
                    end else if (i_push && 3'(g) == o_count) begin
                        mem[g] <= i_data;
                    end
                end
            end
        end
    endgenerate

    // Read data come from the head register.
    assign o_head = mem[0];
endmodule

`default_nettype wire

// ===== verilog/icc_edge.sv
/*
 * Edge detector and event qualifier for one capture channel.
 * Assumes the pin input is already synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module icc_edge (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_ce,
    input  wire logic             i_pin,
    input  wire icc_pkg::icc_mode_e i_mode,
    output logic                  o_event,
    output logic                  o_rise
);
    import icc_pkg::*;
    `include "icc_cfg.svh"

    // -------------------------------------------------------------------------
    // Edge detection and prescaler.
    // -------------------------------------------------------------------------
    logic       pin_q;    // Pin one cycle ago.
    logic [3:0] pscale;   // Rising edges counted toward the prescaled event.
    logic       rise;     // Rising edge this cycle.
    logic       fall;     // Falling edge this cycle.

    assign rise   = i_pin && !pin_q;
    assign fall   = !i_pin && pin_q;
    assign o_rise = rise;

    // Previous pin level.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_q <= 1'b0;
        end else if (i_ce) begin
            pin_q <= i_pin;
        end
    end

    // Prescaler counts rising edges; cleared on reset and when switched off.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pscale <= 4'h0;
        end else if (i_ce) begin
            if (i_mode == ICC_MODE_OFF) begin
                pscale <= 4'h0;
            end else if (rise && (i_mode == ICC_MODE_DIV4 || i_mode == ICC_MODE_DIV16)) begin
                pscale <= pscale + 4'h1;
            end
        end
    end

    // Qualify the event according to the mode field.
    always_comb begin
        unique case (i_mode)
            ICC_MODE_BOTH:  o_event = rise || fall;
            ICC_MODE_FALL:  o_event = fall;
            ICC_MODE_RISE:  o_event = rise;
            ICC_MODE_WAKE:  o_event = rise;
            ICC_MODE_DIV4:  o_event = rise && pscale[1:0] == 2'(`ICC_DIV4_LAST);
            ICC_MODE_DIV16: o_event = rise && pscale == `ICC_DIV16_LAST;
            default:        o_event = 1'b0;
        endcase
    end
endmodule

`default_nettype wire

// ===== verilog/icc_top.sv
/*
 * Eight-channel input capture unit. Each channel watches a pin, qualifies
 * edges per its mode, and pushes the selected timer count into a FIFO.
 * Assumes timer count buses and pins are synchronous to I_CLK, and that
 * the register master never reads and writes in the same cycle.
 */
// How it works
// - Eight independent channels with own state.
// - Mode field picks one of five edge behaviours.
// - Switching channel off clears its prescaler.
// - Any reset clears every prescaler.
// - Four-entry, sixteen-bit FIFO per channel.
// - Not-empty set on capture, until drained.
// - Read returns oldest, others move forward.
// - Fifth event into full buffer sets overflow.
// - Overflowing value is discarded.
// - After overflow ignore events until drained.
// - Bit seven picks timer two or three.
// - Default selection uses timer three.
// - Both-edge mode flags every captured edge.
// - Both-edge mode ignores events-per-interrupt.
// - Both-edge mode never signals overflow.
// - Bits six:five set events per interrupt.
// - Mode seven with enable wakes device.
`timescale 1ns/1ps
`default_nettype none
`include "icc_cfg.svh"

module icc_top #(
    parameter int NCH   = 8,
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic                       I_CLK,
    input  wire logic                       I_RESET_N,
    input  wire logic                       I_CE,
    input  wire logic [NCH-1:0]             I_CAP_PIN,
    input  wire logic [WIDTH-1:0]           I_TMR2_COUNT,
    input  wire logic [WIDTH-1:0]           I_TMR3_COUNT,
    input  wire logic [`ICC_ADDR_W-1:0]     I_ADDR,
    input  wire logic [15:0]                I_WDATA,
    input  wire logic                       I_WR,
    input  wire logic                       I_RD,
    output logic      [15:0]                O_RDATA,
    output logic      [NCH-1:0]             O_IRQ_FLAG,
    output logic                            O_IRQ,
    output logic                            O_WAKE
);
    import icc_pkg::*;

    // -------------------------------------------------------------------------
    // Address decoding helpers.
    // -------------------------------------------------------------------------

    // Channel number encoded in a per-channel address.
    function automatic logic [2:0] chan_of(input logic [`ICC_ADDR_W-1:0] a);
        chan_of = a[`ICC_CH_STRIDE_LOG2 +: 3];
    endfunction

    // True when the address hits the given per-channel word.
    function automatic logic hits(input logic [`ICC_ADDR_W-1:0] a,
                                  input logic [`ICC_ADDR_W-1:0] ofs);
        hits = (a[`ICC_ADDR_W-1:5] == 3'h0) && (a[1:0] == ofs[1:0]);
    endfunction

    // -------------------------------------------------------------------------
    // Shared interrupt registers.
    // -------------------------------------------------------------------------
    logic [NCH-1:0] irq_en;           // Per-channel enables, software written.
    logic [NCH-1:0] irq_set;          // Per-channel flag set pulses this cycle.
    logic [NCH-1:0] irq_clr;          // Per-channel clear pulses from software.
    logic [NCH-1:0] wake_req;         // Per-channel wake conditions.
    logic [15:0]    ch_rdata [NCH];   // Per-channel read mux inputs.
    logic [NCH-1:0] ch_hit;           // Read hit on a channel word.

    // Clear strobe: write-one-to-clear register.
    assign irq_clr = (I_WR && I_ADDR == `ICC_IRQ_CLR_OFS) ? I_WDATA[NCH-1:0] : '0;

    // Enable register.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            irq_en <= '0;
        end else if (I_CE && I_WR && I_ADDR == `ICC_IRQ_EN_OFS) begin
            irq_en <= I_WDATA[NCH-1:0];
        end
    end

    // Sticky flags: a set in the clear cycle wins so no event is lost.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_IRQ_FLAG <= '0;
        end else if (I_CE) begin
            O_IRQ_FLAG <= (O_IRQ_FLAG & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt while any enabled flag is set.
    assign O_IRQ = |(O_IRQ_FLAG & irq_en);

    assign O_WAKE = |(wake_req & irq_en);

    // -------------------------------------------------------------------------
    // Channels.
    // -------------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [7:0]       con;        // Writable control bits.
            logic             ovf;        // Sticky overflow status.
            logic [1:0]       epi_cnt;    // Captures since last interrupt.
            logic             ev;         // Qualified capture event.
            logic             rise;       // Raw rising edge.
            logic             push;       // Value goes into the FIFO.
            logic             pop;        // Software read of the buffer.
            logic [2:0]       count;      // FIFO fill level.
            logic [WIDTH-1:0] head;       // Oldest entry.
            logic [WIDTH-1:0] tval;       // Selected timer count.
            icc_mode_e        mode;       // Decoded mode field.
            logic             both;       // Every-edge mode active.
            logic             full;       // FIFO holds four entries.

            assign mode = icc_mode_e'(con[`ICC_MODE_MSB:`ICC_MODE_LSB]);
            assign both = (mode == ICC_MODE_BOTH);
            assign full = (count == 3'(DEPTH));

            assign tval = con[`ICC_TSEL_BIT] ? I_TMR2_COUNT : I_TMR3_COUNT;

            icc_edge u_edge (
                .i_clk     (I_CLK),
                .i_reset_n (I_RESET_N),
                .i_ce      (I_CE),
                .i_pin     (I_CAP_PIN[c]),
                .i_mode    (mode),
                .o_event   (ev),
                .o_rise    (rise)
            );

            assign push = ev && !full && !ovf;
            assign pop  = I_RD && hits(I_ADDR, `ICC_BUF_OFS) && chan_of(I_ADDR) == 3'(c);

            icc_fifo #(
                .WIDTH (WIDTH),
                .DEPTH (DEPTH)
            ) u_fifo (
                .i_clk     (I_CLK),
                .i_reset_n (I_RESET_N),
                .i_ce      (I_CE),
                .i_push    (push),
                .i_data    (tval),
                .i_pop     (pop),
                .o_head    (head),
                .o_count   (count)
            );

            // Control register; status bits are not written here.
            always_ff @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    con <= 8'(`ICC_CON_RESET);
                end else if (I_CE && I_WR && hits(I_ADDR, `ICC_CON_OFS)
                             && chan_of(I_ADDR) == 3'(c)) begin
                    con <= I_WDATA[7:0] & 8'(`ICC_CON_WMASK);
                end
            end

            // Overflow: set by an event into a full buffer outside both-edge mode, cleared when drained.
            always_ff @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    ovf <= 1'b0;
                end else if (I_CE) begin
                    if (ev && full && !both) begin
                        ovf <= 1'b1;
                    end else if (count == 3'h0 || (count == 3'h1 && pop)) begin
                        ovf <= 1'b0;
                    end
                end
            end

            // Events per interrupt: flag after 1..4 captures.
            always_ff @(posedge I_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    epi_cnt <= 2'h0;
                end else if (I_CE) begin
                    if (mode == ICC_MODE_OFF) begin
                        epi_cnt <= 2'h0;
                    end else if (push && !both) begin
                        epi_cnt <= (epi_cnt == con[`ICC_EPI_MSB:`ICC_EPI_LSB]) ?
                                   2'h0 : epi_cnt + 2'h1;
                    end
                end
            end

            // Flag set pulse; every-edge mode flags each edge directly.
            always_comb begin
                if (both) begin
                    irq_set[c] = ev;
                end else if (mode == ICC_MODE_WAKE) begin
                    irq_set[c] = ev;
                end else begin
                    irq_set[c] = push && epi_cnt == con[`ICC_EPI_MSB:`ICC_EPI_LSB];
                end
            end

            assign wake_req[c] = (mode == ICC_MODE_WAKE) && rise;

            // Read mux input; the buffer word reads the head register.
            always_comb begin
                ch_rdata[c] = 16'h0000;
                ch_hit[c]   = 1'b0;
                if (chan_of(I_ADDR) == 3'(c)) begin
                    if (hits(I_ADDR, `ICC_BUF_OFS)) begin
                        ch_rdata[c] = head;
                        ch_hit[c]   = 1'b1;
                    end else if (hits(I_ADDR, `ICC_CON_OFS)) begin
                        ch_rdata[c] = {8'h00, con};
                        ch_rdata[c][`ICC_BNE_BIT] = (count != 3'h0);
                        ch_rdata[c][`ICC_OV_BIT]  = ovf;
                        ch_hit[c]   = 1'b1;
                    end
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Read data register: valid the cycle after the read strobe only.
    // -------------------------------------------------------------------------
    logic [15:0] next_rdata;  // Selected read value.

    always_comb begin
        next_rdata = 16'h0000;
        if (I_ADDR == `ICC_IRQ_STAT_OFS) begin
            next_rdata = {8'h00, O_IRQ_FLAG};
        end else if (I_ADDR == `ICC_IRQ_EN_OFS) begin
            next_rdata = {8'h00, irq_en};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_hit[i]) begin
                    next_rdata = ch_rdata[i];
                end
            end
        end
    end

    // Unmapped addresses read zero; the bus is zero outside read answers.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_RDATA <= 16'h0000;
        end else if (I_CE) begin
            O_RDATA <= I_RD ? next_rdata : 16'h0000;
        end
    end
endmodule

`default_nettype wire

// ===== tb/icc_top_assertions.sv
/*
 * Port-level checks for the eight-channel capture unit.
 * Assumes icc_top ports and the constants of icc_cfg.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "icc_cfg.svh"

module icc_top_assertions #(
    parameter int NCH   = 8,
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic                   I_CLK,
    input wire logic                   I_RESET_N,
    input wire logic                   I_CE,
    input wire logic [NCH-1:0]         I_CAP_PIN,
    input wire logic [WIDTH-1:0]       I_TMR2_COUNT,
    input wire logic [WIDTH-1:0]       I_TMR3_COUNT,
    input wire logic [`ICC_ADDR_W-1:0] I_ADDR,
    input wire logic [15:0]            I_WDATA,
    input wire logic                   I_WR,
    input wire logic                   I_RD,
    input wire logic [15:0]            O_RDATA,
    input wire logic [NCH-1:0]         O_IRQ_FLAG,
    input wire logic                   O_IRQ,
    input wire logic                   O_WAKE
);
    // -------------------------------------------------------------------
    // One clock domain, so clock and reset are given once.
    // -------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    // Pins held for two cycles, so no edge event can be in flight.
    sequence pin_quiet_s;
        $stable(I_CAP_PIN) [*2];
    endsequence
    // A write that clears every channel flag.
    sequence clear_all_s;
        I_CE && I_WR && I_ADDR == `ICC_IRQ_CLR_OFS && I_WDATA[NCH-1:0] == '1;
    endsequence

    rdata_idle_a: assert property ($past(I_CE) && !$past(I_RD) |-> O_RDATA == 16'h0000)
        else $error("read data not zero outside read answer");
    irq_needs_flag_a: assert property (O_IRQ |-> O_IRQ_FLAG != '0)
        else $error("interrupt high with no flag set");
    wake_on_rise_a: assert property (O_WAKE |-> (I_CAP_PIN & ~$past(I_CAP_PIN)) != '0
        || ($past(I_CAP_PIN) & ~$past(I_CAP_PIN, 2)) != '0) else $error("wake without rise");
    flag_sticky_a: assert property ($past(I_CE) && !$past(I_WR)
        |-> (O_IRQ_FLAG & $past(O_IRQ_FLAG)) == $past(O_IRQ_FLAG)) else $error("flag lost");
    flag_cause_a: assert property ((O_IRQ_FLAG & ~$past(O_IRQ_FLAG)) != '0
        |-> $past(I_CAP_PIN) != $past(I_CAP_PIN, 2) || $past(I_CAP_PIN, 2) != $past(I_CAP_PIN, 3))
        else $error("flag set without pin edge");
    freeze_flags_a: assert property (!I_CE |=> $stable(O_IRQ_FLAG))
        else $error("flags moved while clock enable low");
    clear_flags_a: assert property (pin_quiet_s ##0 clear_all_s |=> O_IRQ_FLAG == '0)
        else $error("flags not cleared");
    reset_quiet_a: assert property ($rose(I_RESET_N) |-> O_IRQ_FLAG == '0 && !O_IRQ)
        else $error("outputs not cleared by reset");
endmodule

bind icc_top icc_top_assertions #(.NCH(NCH), .WIDTH(WIDTH), .DEPTH(DEPTH)) icc_top_assertions_i (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CE(I_CE), .I_CAP_PIN(I_CAP_PIN),
    .I_TMR2_COUNT(I_TMR2_COUNT), .I_TMR3_COUNT(I_TMR3_COUNT), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_IRQ_FLAG(O_IRQ_FLAG), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));
`default_nettype wire

// ===== tb/icc_pin_model.sv
/*
 * External signal source for the capture pins.
 * Assumes the bench calls its task; pins idle low, driven push-pull.
 */
`timescale 1ns/1ps
`default_nettype none

module icc_pin_model #(
    parameter int NCH = 8
) (
    input  wire logic           i_clk,
    output logic      [NCH-1:0] o_pin
);
    initial o_pin = '0;

    // Moves one pin just after an edge, then holds it three cycles so
    // that every transition is seen as a separate event.
    task automatic drive(input int ch, input logic lvl);
        @(posedge i_clk);
        o_pin[ch] <= lvl;
        repeat (3) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/icc_top_tb.sv
/*
 * Self-checking bench for the capture unit: register tasks and scenarios.
 * Assumes icc_pkg, icc_cfg.svh and icc_pin_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "icc_cfg.svh"

module icc_top_tb;
    import icc_pkg::*;
    logic        clk, reset_n, ce, wr, rd, irq, wake;
    logic [7:0]  addr, irq_flag;
    logic [15:0] wdata, tmr2, tmr3, rdata;
    wire  [7:0]  cap_pin;
    int          failures, check_count, wake_seen;
    logic [15:0] exp_con [7] = '{16'h0080, 16'h0089, 16'h009A, 16'h009B,
                                 16'h008C, 16'h008D, 16'h0086};
    int          exp_cnt [7] = '{0, 4, 4, 4, 4, 1, 0};

    icc_top icc_top_i (.I_CLK(clk), .I_RESET_N(reset_n), .I_CE(ce), .I_CAP_PIN(cap_pin),
        .I_TMR2_COUNT(tmr2), .I_TMR3_COUNT(tmr3), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ_FLAG(irq_flag), .O_IRQ(irq),
        .O_WAKE(wake));
    icc_pin_model icc_pin_model_i (.i_clk(clk), .o_pin(cap_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Wake is a one-cycle pulse; count it mid-cycle, away from the edge.
    always @(negedge clk) begin
        if (wake === 1'b1) wake_seen++;
    end

    function automatic logic [7:0] con_a(input int ch);
        return 8'(ch << `ICC_CH_STRIDE_LOG2) + `ICC_CON_OFS;
    endfunction
    function automatic logic [7:0] buf_a(input int ch);
        return 8'(ch << `ICC_CH_STRIDE_LOG2) + `ICC_BUF_OFS;
    endfunction
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read data stands only in the cycle after the strobe, so sample it there.
    task automatic check_reg(input string what, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            icc_pin_model_i.drive(ch, 1'b1);
            icc_pin_model_i.drive(ch, 1'b0);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs far fewer cycles.
    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial begin
        {reset_n, wr, rd, addr, wdata} = '0;
        ce   = 1'b1;
        tmr2 = 16'hA5A5;
        tmr3 = 16'h5A5A;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        check_reg("ch0 control", con_a(0), 16'h0000);
        check_reg("flag status", `ICC_IRQ_STAT_OFS, 16'h0000);
        check_reg("unmapped", 8'h30, 16'h0000);
        reg_write(con_a(5), 16'hFFFF);
        check_reg("ch5 control", con_a(5), `ICC_CON_WMASK);
        reg_write(con_a(5), 16'h0000);
        $display("test reset and access done");

        // Fill ch0, overflow it, then drain while an event is ignored.
        reg_write(con_a(0), 16'(ICC_MODE_RISE));
        for (int i = 1; i <= 5; i++) begin
            @(posedge clk);
            tmr3 <= 16'h1000 + 16'(i);
            pulse(0, 1);
            if (i == 4) check_reg("ch0 full", con_a(0), 16'h000B);
        end
        check_reg("ch0 overflow", con_a(0), 16'h001B);
        check_reg("ch0 buffer", buf_a(0), 16'h1001);
        tmr3 <= 16'h1099;
        pulse(0, 1);
        for (int i = 2; i <= 4; i++) check_reg("ch0 buffer", buf_a(0), 16'h1000 + 16'(i));
        check_reg("ch0 drained", con_a(0), 16'h0003);
        tmr3 <= 16'h1077;
        pulse(0, 1);
        check_reg("ch0 new capture", buf_a(0), 16'h1077);
        $display("test fifo and overflow done");

        // Modes zero to six on ch1 with timer two selected, 16 rise/fall pairs.
        for (int m = 0; m < 7; m++) begin
            reg_write(`ICC_IRQ_CLR_OFS, 16'h00FF);
            reg_write(con_a(1), 16'h0080 | 16'(m));
            pulse(1, 16);
            check_reg("ch1 control", con_a(1), exp_con[m]);
            check_reg("ch1 flag", `ICC_IRQ_STAT_OFS, exp_cnt[m] > 0 ? 16'h0002 : 16'h0000);
            for (int k = 0; k < exp_cnt[m]; k++) check_reg("ch1 buffer", buf_a(1), 16'hA5A5);
            reg_write(con_a(1), 16'h0000);
        end
        $display("test modes done");

        // Prescaler cleared by switching off and by reset.
        reg_write(con_a(2), 16'(ICC_MODE_DIV4));
        pulse(2, 3);
        reg_write(con_a(2), 16'h0000);
        reg_write(con_a(2), 16'(ICC_MODE_DIV4));
        pulse(2, 3);
        check_reg("ch2 after off", con_a(2), 16'h0004);
        pulse(2, 1);
        check_reg("ch2 capture", con_a(2), 16'h000C);
        // Timer three still holds the last value set in the buffer test.
        check_reg("ch2 buffer", buf_a(2), 16'h1077);
        pulse(2, 3);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_write(con_a(2), 16'(ICC_MODE_DIV4));
        pulse(2, 1);
        check_reg("ch2 after reset", con_a(2), 16'h0004);
        $display("test prescaler done");

        // Two captures per flag on ch3, then mask, freeze and clear.
        reg_write(`ICC_IRQ_EN_OFS, 16'h0008);
        check_reg("enable", `ICC_IRQ_EN_OFS, 16'h0008);
        reg_write(con_a(3), 16'h0023);
        pulse(3, 1);
        check("irq one capture", 16'(irq), 16'h0000);
        pulse(3, 1);
        check_reg("ch3 flag", `ICC_IRQ_STAT_OFS, 16'h0008);
        check("irq raised", 16'(irq), 16'h0001);
        check("flag port", 16'(irq_flag), 16'h0008);
        reg_write(`ICC_IRQ_EN_OFS, 16'h0000);
        check("irq masked", 16'(irq), 16'h0000);
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        reg_write(`ICC_IRQ_CLR_OFS, 16'h0008);
        check_reg("ch3 cleared", `ICC_IRQ_STAT_OFS, 16'h0000);
        reg_write(`ICC_IRQ_EN_OFS, 16'h0010);
        reg_write(con_a(4), 16'(ICC_MODE_WAKE));
        wake_seen = 0;
        pulse(4, 1);
        check("wake pulses", 16'(wake_seen), 16'h0001);
        check("irq wake", 16'(irq), 16'h0001);
        $display("test interrupts done");
        report_and_stop();
    end
endmodule
`default_nettype wire
